// [hw/xbc_pkg.sv]
package xbc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int PORT_W = 3;

  // ==========================================================
  // bus cycle phases (four input clocks per cpu clock)
  localparam logic [1:0] PH_FIRST    = 2'h0;
  localparam logic [1:0] PH_STROBE   = 2'h1;
  localparam logic [1:0] PH_WRITE    = 2'h2;
  localparam logic [1:0] PH_LAST     = 2'h3;
  localparam logic [1:0] PH_CLK_HIGH = 2'h2;

  localparam logic [ADDR_W-1:0] INT_ROM_WORDS = 16'h2000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO     = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE      = 16'h0001;

  // ==========================================================
  // wishbone register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_TARGET = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_PC     = 8'h18;
  localparam logic [7:0] REG_INSTR  = 8'h1c;

  localparam int CTRL_IRQ_EN  = 0;
  localparam int CTRL_OVM     = 1;
  localparam int CMD_PORT_LSB = 3;
  localparam int ST_BUSY      = 0;
  localparam int ST_IRQ_FLAG  = 1;
  localparam int ST_IRQ_REQ   = 2;
  localparam int ST_POLL      = 3;
  localparam int ST_IN_RESET  = 4;
  localparam int ST_INTERNAL  = 5;

  // ==========================================================
  // commands written to REG_CMD bits [2:0]
  localparam logic [2:0] OP_NONE        = 3'h0;
  localparam logic [2:0] OP_IN          = 3'h1;
  localparam logic [2:0] OP_OUT         = 3'h2;
  localparam logic [2:0] OP_TABLE_STORE = 3'h3;
  localparam logic [2:0] OP_POLL_BRANCH = 3'h4;
  localparam logic [2:0] OP_GRANT       = 3'h5;

  typedef enum logic [2:0] {
    K_IDLE, K_FETCH, K_IN, K_OUT, K_DUMMY, K_TWRITE
  } xbc_kind_type;

endpackage

// [hw/xbc_bus_ctrl.sv]
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module xbc_bus_ctrl (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // wishbone classic slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // device pins
  input  wire logic                       reset_pin_n_i,
  input  wire logic                       branch_poll_input_n_i,
  input  wire logic                       irq_input_n_i,
  input  wire logic                       memory_map_select_i,
  input  wire logic [xbc_pkg::DATA_W-1:0] data_i,
  output logic      [xbc_pkg::DATA_W-1:0] data_o,
  output logic                            data_oe_n_o,
  output logic      [xbc_pkg::ADDR_W-1:0] address_outputs_o,
  output logic                            cpu_clock_output_o,
  output logic                            program_fetch_strobe_n_o,
  output logic                            port_read_strobe_n_o,
  output logic                            port_write_strobe_n_o,
  output logic                            table_write_strobe_n_o,
  output logic                            irq_request_o
);
  import xbc_pkg::*;

  // ==========================================================
  // state
  logic [1:0]          phase_q;
  xbc_kind_type        kind_q;
  logic [ADDR_W-1:0]   pc_q, addr_q, target_q;
  logic [DATA_W-1:0]   wdata_q, rdata_q, instr_q;
  logic [PORT_W-1:0]   port_q;
  logic [2:0]          op_q;
  logic                pend_q;
  logic                irq_en_q, ovm_q, irq_flag_q, irq_prev_q;
  logic                poll_q;
  logic                rp_s1_q, rp_s2_q;
  logic                pl_s1_q, pl_s2_q;
  logic                ir_s1_q, ir_s2_q;
  logic                in_reset_q, held_q, rel_q;
  logic                internal_q;
  logic                ack_q;
  logic [31:0]         rdat_q;
  logic                clk_out_q, fetch_n_q, rd_n_q, wr_n_q, tw_n_q, oe_n_q;
  logic [DATA_W-1:0]   dout_q;

  // ==========================================================
  // decode
  wire logic [1:0]  phase_d    = phase_q + 2'h1;
  wire logic        boundary   = (phase_q == PH_LAST);
  wire logic        wb_acc     = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic        wb_wr      = wb_acc && wb_we_i;
  wire logic        wr_ctrl    = wb_wr && (wb_adr_i == REG_CTRL);
  wire logic        wr_cmd     = wb_wr && (wb_adr_i == REG_CMD) && wb_sel_i[0];
  wire logic        wr_target  = wb_wr && (wb_adr_i == REG_TARGET);
  wire logic        wr_wdata   = wb_wr && (wb_adr_i == REG_WDATA);
  wire logic [15:0] lane_mask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [2:0]  cmd_op     = wb_dat_i[2:0];
  wire logic        cmd_grant  = wr_cmd && (cmd_op == OP_GRANT);
  wire logic        cmd_accept = wr_cmd && !pend_q && !in_reset_q
                                 && (cmd_op != OP_NONE) && (cmd_op != OP_GRANT);
  // reset pin after its two-flop synchroniser, high while the pin is held low
  wire logic        rp_low     = !rp_s2_q;
  wire logic        busy       = pend_q || (kind_q == K_DUMMY);
  // poll sampled at the cpu clock fall; low means branch
  wire logic        poll_take  = pend_q && (op_q == OP_POLL_BRANCH) && !poll_q;
  wire logic        irq_low    = !ir_s2_q;
  // a falling edge and a sustained low level both set the flag
  wire logic        irq_set    = boundary && (irq_low || (irq_prev_q && irq_low));

  // ==========================================================
  // next bus cycle kind, chosen at the cpu clock fall
  xbc_kind_type kind_d;
  always_comb begin
    kind_d = K_FETCH;
    if (in_reset_q || rp_low) begin
      kind_d = K_IDLE;
    end else if (kind_q == K_DUMMY) begin
      kind_d = K_TWRITE;
    end else if (pend_q) begin
      case (op_q)
        OP_IN:   kind_d = K_IN;
        OP_OUT:  kind_d = K_OUT;
        OP_TABLE_STORE: kind_d = K_DUMMY;
        default: kind_d = K_FETCH;
      endcase
    end
  end

  wire logic [ADDR_W-1:0] pc_eff   = poll_take ? target_q : pc_q;
  wire logic [ADDR_W-1:0] port_adr = {{(ADDR_W-PORT_W){1'b0}}, port_q};
  logic [ADDR_W-1:0] addr_d;
  always_comb begin
    case (kind_d)
      K_IN, K_OUT: addr_d = port_adr;
      K_TWRITE:    addr_d = target_q;
      K_IDLE:      addr_d = addr_q;
      default:     addr_d = pc_eff;
    endcase
  end

  // strobe timing inside a cycle, given the phase about to begin
  wire logic ph_strobe = (phase_d != PH_FIRST);
  wire logic ph_write  = (phase_d >= PH_WRITE);
  wire logic gate      = !in_reset_q && !rp_low;
  wire logic fetch_on  = gate && ph_strobe && ((kind_q == K_FETCH) || (kind_q == K_DUMMY));
  wire logic rd_on     = gate && ph_strobe && (kind_q == K_IN);
  wire logic wr_on     = gate && ph_write && (kind_q == K_OUT);
  wire logic tw_on     = gate && ph_write && (kind_q == K_TWRITE);
  wire logic is_int    = memory_map_select_i && (addr_q < INT_ROM_WORDS);

  // ==========================================================
  // synchronisers
  // the reset, poll and irq pins pass two flops before any logic reads them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rp_s1_q <= 1'b1;
      rp_s2_q <= 1'b1;
      pl_s1_q <= 1'b1;
      pl_s2_q <= 1'b1;
      ir_s1_q <= 1'b1;
      ir_s2_q <= 1'b1;
    end else if (ce_i) begin
      rp_s1_q <= reset_pin_n_i;
      rp_s2_q <= rp_s1_q;
      pl_s1_q <= branch_poll_input_n_i;
      pl_s2_q <= pl_s1_q;
      ir_s1_q <= irq_input_n_i;
      ir_s2_q <= ir_s1_q;
    end
  end

  // ==========================================================
  // cycle sequencer and pin reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q    <= PH_FIRST;
      kind_q     <= K_IDLE;
      in_reset_q <= 1'b1;
      held_q     <= 1'b0;
      rel_q      <= 1'b0;
      poll_q     <= 1'b1;
      irq_prev_q <= 1'b1;
    end else if (ce_i) begin
      phase_q <= phase_d;
      if (rp_low) begin
        in_reset_q <= 1'b1;
        rel_q      <= 1'b0;
      end
      if (boundary) begin
        poll_q     <= pl_s2_q;
        irq_prev_q <= ir_s2_q;
        kind_q     <= kind_d;
        if (rp_low) begin
          held_q <= 1'b1;
        end else if (in_reset_q) begin
          // release: one full cpu clock with rel_q set, then fetch from pc
          held_q <= 1'b0;
          rel_q  <= 1'b1;
          if (rel_q) begin
            in_reset_q <= 1'b0;
            rel_q      <= 1'b0;
            kind_q     <= K_FETCH;
          end
        end
      end
    end
  end

  // ==========================================================
  // program counter, address, captured data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q       <= ADDR_ZERO;
      addr_q     <= ADDR_ZERO;
      rdata_q    <= '0;
      instr_q    <= '0;
      internal_q <= 1'b0;
    end else if (ce_i && boundary) begin
      if (in_reset_q || rp_low) begin
        // second cpu clock fall seen with the pin low clears pc and address
        if (held_q && rp_low) begin
          pc_q   <= ADDR_ZERO;
          addr_q <= ADDR_ZERO;
        end else if (in_reset_q && rel_q) begin
          addr_q <= pc_q;
          pc_q   <= pc_q + ADDR_ONE;
        end
      end else begin
        addr_q <= addr_d;
        if (kind_d == K_FETCH) begin
          pc_q <= pc_eff + ADDR_ONE;
        end
        if (kind_q == K_IN) begin
          rdata_q <= data_i;
        end
        if (kind_q == K_FETCH) begin
          internal_q <= is_int;
          if (!is_int) begin
            instr_q <= data_i;
          end
        end
      end
    end
  end

  // ==========================================================
  // command, control and interrupt flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q     <= 1'b0;
      op_q       <= OP_NONE;
      port_q     <= '0;
      target_q   <= ADDR_ZERO;
      wdata_q    <= '0;
      irq_en_q   <= 1'b0;
      ovm_q      <= 1'b0;
      irq_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_target) begin
        target_q <= (target_q & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
      end
      if (wr_wdata) begin
        wdata_q <= (wdata_q & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
      end
      if (wr_ctrl && wb_sel_i[0]) begin
        irq_en_q <= wb_dat_i[CTRL_IRQ_EN];
        ovm_q    <= wb_dat_i[CTRL_OVM];
      end
      if (cmd_accept) begin
        pend_q <= 1'b1;
        op_q   <= cmd_op;
        port_q <= wb_dat_i[CMD_PORT_LSB +: PORT_W];
      end else if (boundary && pend_q && !in_reset_q && !rp_low) begin
        pend_q <= 1'b0;
      end
      // a new interrupt sample wins over a grant in the same cycle
      if (irq_set) begin
        irq_flag_q <= 1'b1;
      end else if (cmd_grant) begin
        irq_flag_q <= 1'b0;
      end
      // pin reset overrides the pending command, irq enable and flag updates above; overflow mode is kept
      if (rp_low) begin
        pend_q     <= 1'b0;
        irq_en_q   <= 1'b0;
        irq_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // registered pins
  // pins follow the phase about to begin, so each one comes straight
  // from a flip-flop and every strobe is high throughout phase 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_q <= 1'b0;
      fetch_n_q <= 1'b1;
      rd_n_q    <= 1'b1;
      wr_n_q    <= 1'b1;
      tw_n_q    <= 1'b1;
      oe_n_q    <= 1'b1;
      dout_q    <= '0;
    end else if (ce_i) begin
      clk_out_q <= (phase_d >= PH_CLK_HIGH);
      fetch_n_q <= !fetch_on;
      rd_n_q    <= !rd_on;
      wr_n_q    <= !wr_on;
      tw_n_q    <= !tw_on;
      oe_n_q    <= !(wr_on || tw_on);
      dout_q    <= wdata_q;
    end
  end

  // ==========================================================
  // wishbone read path
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      REG_CTRL: begin
        rd_mux[CTRL_IRQ_EN] = irq_en_q;
        rd_mux[CTRL_OVM]    = ovm_q;
      end
      REG_CMD:    rd_mux[5:0] = {port_q, op_q};
      REG_TARGET: rd_mux[15:0] = target_q;
      REG_WDATA:  rd_mux[15:0] = wdata_q;
      REG_RDATA:  rd_mux[15:0] = rdata_q;
      REG_STATUS: begin
        rd_mux[ST_BUSY]     = busy;
        rd_mux[ST_IRQ_FLAG] = irq_flag_q;
        rd_mux[ST_IRQ_REQ]  = irq_flag_q && irq_en_q;
        rd_mux[ST_POLL]     = poll_q;
        rd_mux[ST_IN_RESET] = in_reset_q;
        rd_mux[ST_INTERNAL] = internal_q;
      end
      REG_PC:     rd_mux[15:0] = pc_q;
      REG_INSTR:  rd_mux[15:0] = instr_q;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // ack one cycle after the request is taken; ce low holds it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q  <= wb_acc;
      rdat_q <= rd_mux;
    end
  end

  logic irq_req_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_q <= 1'b0;
    end else if (ce_i) begin
      irq_req_q <= irq_flag_q && irq_en_q;
    end
  end

  assign wb_ack_o                 = ack_q;
  assign wb_dat_o                 = rdat_q;
  assign data_o                   = dout_q;
  assign data_oe_n_o              = oe_n_q;
  assign address_outputs_o        = addr_q;
  assign cpu_clock_output_o       = clk_out_q;
  assign program_fetch_strobe_n_o = fetch_n_q;
  assign port_read_strobe_n_o     = rd_n_q;
  assign port_write_strobe_n_o    = wr_n_q;
  assign table_write_strobe_n_o   = tw_n_q;
  assign irq_request_o            = irq_req_q;

endmodule
`default_nettype wire

// [test/xbc_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module xbc_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        reset_pin_n_i,
  input wire logic        data_oe_n_o,
  input wire logic [15:0] address_outputs_o,
  input wire logic        cpu_clock_output_o,
  input wire logic        program_fetch_strobe_n_o,
  input wire logic        port_read_strobe_n_o,
  input wire logic        port_write_strobe_n_o,
  input wire logic        table_write_strobe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  wire logic [3:0] stb_n = {program_fetch_strobe_n_o, port_read_strobe_n_o,
                            port_write_strobe_n_o, table_write_strobe_n_o};
  // ==========================================================
  // pin bus
  AST_ONE_STROBE:
    assert property ($countones(~stb_n) <= 1) else $error("two strobes low");
  AST_BUS_RELEASE:
    assert property (!data_oe_n_o |-> (!port_write_strobe_n_o || !table_write_strobe_n_o))
    else $error("data driven without write strobe");
  AST_PORT_ADDR:
    assert property ((!port_read_strobe_n_o || !port_write_strobe_n_o)
      |-> address_outputs_o[15:3] == 13'h0000) else $error("port address upper bits set");
  AST_READ_NO_DRIVE:
    assert property (!port_read_strobe_n_o |-> data_oe_n_o) else $error("drive on port read");
  AST_PIN_RESET:
    assert property ($fell(reset_pin_n_i) |-> ##3 (&stb_n && data_oe_n_o))
    else $error("pin reset left bus active");
  AST_CLK_DIV:
    assert property ($rose(cpu_clock_output_o) |=> cpu_clock_output_o ##1
      !cpu_clock_output_o [*2] ##1 cpu_clock_output_o) else $error("cpu clock not div 4");
  AST_PHASE0_IDLE:
    assert property ($fell(cpu_clock_output_o) |-> &stb_n) else $error("strobe low in phase 0");
  AST_FETCH_ADDR:
    assert property ($fell(program_fetch_strobe_n_o) |-> $stable(address_outputs_o) [*3])
    else $error("address moved in fetch");
  AST_TW_DRIVE:
    assert property ($fell(table_write_strobe_n_o) |-> !data_oe_n_o ##1 !data_oe_n_o)
    else $error("table write not driving data");
  // ==========================================================
  // register bus
  AST_ACK_NEXT:
    assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i) |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONCE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule
bind xbc_bus_ctrl xbc_asserts xbc_asserts_inst (
  .clk_i                    (clk_i),
  .rst_i                    (rst_i),
  .ce_i                     (ce_i),
  .wb_cyc_i                 (wb_cyc_i),
  .wb_stb_i                 (wb_stb_i),
  .wb_ack_o                 (wb_ack_o),
  .reset_pin_n_i            (reset_pin_n_i),
  .data_oe_n_o              (data_oe_n_o),
  .address_outputs_o        (address_outputs_o),
  .cpu_clock_output_o       (cpu_clock_output_o),
  .program_fetch_strobe_n_o (program_fetch_strobe_n_o),
  .port_read_strobe_n_o     (port_read_strobe_n_o),
  .port_write_strobe_n_o    (port_write_strobe_n_o),
  .table_write_strobe_n_o   (table_write_strobe_n_o)
);
`default_nettype wire

// [test/xbc_ext_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module xbc_ext_mem (
  input  wire logic        clk_i,
  input  wire logic [15:0] address_i,
  input  wire logic [15:0] data_i,
  input  wire logic        data_oe_n_i,
  input  wire logic        fetch_n_i,
  input  wire logic        read_n_i,
  input  wire logic        pwrite_n_i,
  input  wire logic        twrite_n_i,
  output logic      [15:0] data_o
);
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] idle_q  = 16'h0000;
  logic        wr_port = 1'b0;
  // zero wait: answers in the same cycle the strobe is low
  always_comb begin
    if (!fetch_n_i) data_o = address_i ^ 16'ha5c3;
    else if (!read_n_i) data_o = 16'h3c00 | address_i;
    else data_o = idle_q;
  end
  // released bus reads a constant zero, since idle_q stays 0; any write address accepted
  always @(posedge clk_i) begin
    idle_q <= ~idle_q + 16'h0001;
    if ((!pwrite_n_i || !twrite_n_i) && !data_oe_n_i) begin
      wr_data <= data_i;
      wr_port <= !pwrite_n_i;
    end
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import xbc_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
  logic rpin_n = 1, poll_n = 1, irq_n = 1, map = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rq, wb_dat_o;
  logic [15:0] dev_dq, mdl_dq, addr, d, t;
  logic wb_ack_o, oe_n, cpuclk, fetch_n, rd_n, wr_n, tw_n, irq_req, hit;
  int seed = 45526, n_errors = 0, n_checks = 0;
  wire logic [15:0] bus = !oe_n ? dev_dq : mdl_dq;
  wire logic [3:0] sn = {fetch_n, rd_n, wr_n, tw_n};
  xbc_bus_ctrl xbc_bus_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_pin_n_i(rpin_n),
    .branch_poll_input_n_i(poll_n), .irq_input_n_i(irq_n), .memory_map_select_i(map),
    .data_i(bus), .data_o(dev_dq), .data_oe_n_o(oe_n), .address_outputs_o(addr),
    .cpu_clock_output_o(cpuclk), .program_fetch_strobe_n_o(fetch_n),
    .port_read_strobe_n_o(rd_n), .port_write_strobe_n_o(wr_n),
    .table_write_strobe_n_o(tw_n), .irq_request_o(irq_req));
  xbc_ext_mem xbc_ext_mem_inst (.clk_i(clk_i), .address_i(addr), .data_i(bus),
    .data_oe_n_i(oe_n), .fetch_n_i(fetch_n), .read_n_i(rd_n), .pwrite_n_i(wr_n),
    .twrite_n_i(tw_n), .data_o(mdl_dq));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [15:0] exp_port(input logic [2:0] p);
    return {13'h0780, p};
  endfunction
  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= v; sel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) n_errors++;
    rq = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wstb(input int k);
    int n;
    n = 0;
    while (sn[k] !== 1'b0 && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 64) n_errors++;
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while (rq[ST_BUSY] !== 1'b0 && n < 40);
    if (rq[ST_BUSY] !== 1'b0) n_errors++;
  endtask
  task automatic pin_reset;
    rpin_n <= 0;
    repeat (24) @(posedge clk_i);
    chk("strobes", 5'h1f, {sn, oe_n});
    chk("reset addr", 0, addr);
    rpin_n <= 1;
    wstb(3);
    chk("first fetch", 0, addr);
  endtask
  task automatic irq_pulse;
    irq_n <= 0;
    repeat (6) @(posedge clk_i);
    irq_n <= 1;
    repeat (12) @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    pin_reset();
    rd(8'h20);
    chk("unmapped", 0, rq);
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      wr(REG_WDATA, {16'h0, d});
      wr(REG_CMD, 32'({i[2:0], OP_OUT}));
      wstb(1);
      chk("out addr", i, addr);
      idle();
      chk("out data", {wr_n, d}, {1'b1, xbc_ext_mem_inst.wr_data});
      wr(REG_CMD, 32'({i[2:0], OP_IN}));
      wstb(2);
      chk("in addr", i, addr);
      idle();
      rd(REG_RDATA);
      chk("in data", exp_port(i[2:0]), rq);
    end
    t = 16'($random(seed));
    d = 16'($random(seed));
    wr(REG_TARGET, {16'h0, t});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, 32'(OP_TABLE_STORE));
    wstb(0);
    chk("tw addr", t, addr);
    idle();
    chk("tw data", {1'b0, d}, {xbc_ext_mem_inst.wr_port, xbc_ext_mem_inst.wr_data});
    map <= 1;
    repeat (12) @(posedge clk_i);
    wstb(3);
    rd(REG_STATUS);
    chk("internal", 1, rq[ST_INTERNAL]);
    map <= 0;
    repeat (12) @(posedge clk_i);
    rd(REG_STATUS);
    chk("external", 0, rq[ST_INTERNAL]);
    wr(REG_CTRL, 32'h3);
    irq_pulse();
    chk("irq req", 1, irq_req);
    wr(REG_CMD, 32'(OP_GRANT));
    rd(REG_STATUS);
    chk("granted", 0, rq[ST_IRQ_FLAG]);
    for (int k = 1; k >= 0; k--) begin
      poll_n <= k[0];
      t = 16'h8000 | 16'($random(seed));
      wr(REG_TARGET, {16'h0, t});
      wr(REG_CMD, 32'(OP_POLL_BRANCH));
      hit = 0;
      repeat (40) begin
        @(posedge clk_i);
        if (fetch_n === 1'b0 && addr === t) hit = 1;
      end
      chk("branch", !k[0], hit);
    end
    ce_i <= 0;
    repeat (2) @(posedge clk_i);
    rq = 32'({addr, sn, cpuclk, oe_n});
    repeat (9) @(posedge clk_i);
    chk("ce freeze", rq, 32'({addr, sn, cpuclk, oe_n}));
    ce_i <= 1;
    irq_pulse();
    pin_reset();
    rd(REG_CTRL);
    chk("ctrl kept", 2, rq[1:0]);
    rd(REG_STATUS);
    chk("flag clear", 0, rq[ST_IRQ_FLAG]);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
